// ===== src/tcr_pkg.sv
// Purpose: constants and types for the 16-bit timer with capture and compare
// Assumes: 8-bit I/O register bus, 100 MHz I/O clock
// Notes:   register indexes are local I/O addresses of this block
// Function
// R1: filter needs four equal capture samples
// R2: filter adds four clock delay
// R3: edge select 0 falling, 1 rising
// R4: capture copies counter and sets flag
// R5: capture request only when enabled
// R6: capture top mode disables capture
// R7: software writes zero to reserved bit
// R8: clock select stop, direct, prescaled taps
// R9: codes 110/111 count external pin edges
// R10: external pin counts even as output
// R11: counter byte access via shared latch
// R12: counter write blocks next compare match
// R13: compare values matched against counter continuously
// R14: compare writes commit both bytes together
// R15: capture from pin or comparator; top
// R16: capture reads consistent via latch
// R17: mask bit 7 enables overflow request
// R18: mask bit 6 enables compare A
// R19: mask bit 5 enables compare B
// R20: mask bit 3 enables capture request
// R21: compare flag set one tick later
// R22: flags clear on vector or write-one
// R23: high byte written first, low read first
package tcr_pkg;

  // ------------------------------------------------------------------
  // register indexes on the I/O bus
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL_FIRST  = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_SECOND = 4'h1;
  localparam logic [3:0] ADDR_COUNTER_LO     = 4'h2;
  localparam logic [3:0] ADDR_COUNTER_HI     = 4'h3;
  localparam logic [3:0] ADDR_COMPARE_A_LO   = 4'h4;
  localparam logic [3:0] ADDR_COMPARE_A_HI   = 4'h5;
  localparam logic [3:0] ADDR_COMPARE_B_LO   = 4'h6;
  localparam logic [3:0] ADDR_COMPARE_B_HI   = 4'h7;
  localparam logic [3:0] ADDR_CAPTURE_LO     = 4'h8;
  localparam logic [3:0] ADDR_CAPTURE_HI     = 4'h9;
  localparam logic [3:0] ADDR_IRQ_MASK       = 4'ha;
  localparam logic [3:0] ADDR_IRQ_FLAGS      = 4'hb;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_NOISE_FILTER = 7;
  localparam int BIT_EDGE_SELECT  = 6;
  localparam int BIT_RESERVED     = 5;
  localparam int BIT_WAVE_HI      = 4;
  localparam int BIT_WAVE_LO      = 3;
  localparam int BIT_OVERFLOW     = 7;
  localparam int BIT_COMPARE_A    = 6;
  localparam int BIT_COMPARE_B    = 5;
  localparam int BIT_CAPTURE      = 3;

  // ------------------------------------------------------------------
  // reset values and encodings
  // ------------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [7:0]  FLAG_MASK   = 8'he8;
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [2:0]  CS_DIRECT   = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;
  // prescaler taps: divide by 8, 64, 256, 1024 as last-count values
  localparam logic [9:0]  TAP_DIV8    = 10'h007;
  localparam logic [9:0]  TAP_DIV64   = 10'h03f;
  localparam logic [9:0]  TAP_DIV256  = 10'h0ff;
  localparam logic [9:0]  TAP_DIV1024 = 10'h3ff;
  // waveform modes that use the capture register as top
  localparam logic [3:0]  WGM_PFC_CAPTOP  = 4'h8;
  localparam logic [3:0]  WGM_PC_CAPTOP   = 4'ha;
  localparam logic [3:0]  WGM_CTC_CAPTOP  = 4'hc;
  localparam logic [3:0]  WGM_FAST_CAPTOP = 4'he;
  // noise filter depth in samples
  localparam int          FILTER_SAMPLES  = 4;
  localparam logic [1:0]  FILTER_LAST     = 2'(FILTER_SAMPLES - 1);

  // ------------------------------------------------------------------
  // bus carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       write;
    logic       read;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tcr_bus_req_t;

  typedef struct packed {
    logic overflow;
    logic compare_a;
    logic compare_b;
    logic capture;
  } tcr_irq_t;

endpackage

// ===== src/tcr_filter.sv
// Purpose: capture input noise filter
// Assumes: input already synchronised to clock
// Notes:   output moves after four equal samples when enabled
`timescale 1ns/100ps
module tcr_filter (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic sample_in,
  output logic      filtered
);

  logic [1:0] run_count;
  logic       last_sample;
  wire        differs  = (sample_in != filtered);
  wire        same_run = (sample_in == last_sample);

  // -----------------------------------------------------------------
  // run-length filter
  // -----------------------------------------------------------------
  // counting equal samples costs four cycles of latency, traded for glitch immunity
  always_ff @(posedge clock) begin
    if (!nrst) begin
      run_count   <= 2'h0;
      last_sample <= 1'b1;
      filtered    <= 1'b1;
    end else begin
      last_sample <= sample_in;
      if (!enable) begin
        filtered  <= sample_in;
        run_count <= 2'h0;
      end else if (differs && !same_run) begin
        run_count <= 2'h1;
      end else if (differs && run_count == tcr_pkg::FILTER_LAST) begin
        filtered  <= sample_in; // R1 R2
        run_count <= 2'h0;
      end else if (differs) begin
        run_count <= run_count + 2'h1;
      end else begin
        run_count <= 2'h0;
      end
    end
  end

endmodule

// ===== src/tcr_timer.sv
// Purpose: 16-bit timer with prescaler, capture, compare and mask
// Assumes: single 100 MHz clock, core strobes one-cycle read/write
// Notes:   read data is registered, valid one cycle after read strobe
`timescale 1ns/100ps
module tcr_timer (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire tcr_pkg::tcr_bus_req_t bus_req,
  output logic [7:0]                rdata,
  input  wire logic                 global_irq_enable,
  input  wire tcr_pkg::tcr_irq_t    vector_ack,
  input  wire logic                 capture_input_pin,
  input  wire logic                 comparator_out,
  input  wire logic                 comparator_capture_select,
  input  wire logic                 external_count_pin,
  output tcr_pkg::tcr_irq_t         irq_request,
  output logic                      match_a,
  output logic                      match_b
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0]  timer_control_first;
  logic [7:0]  timer_control_second;
  logic [7:0]  timer_irq_mask;
  logic [7:0]  timer_irq_flags;
  logic [15:0] counter_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic [7:0]  high_latch;
  logic [9:0]  prescale;
  logic        write_block;
  logic [2:0]  cap_sync;
  logic [2:0]  ext_sync;
  logic        cap_prev;
  logic        ext_prev;
  logic        cmp_prev;
  logic        cap_filtered;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire       wr = bus_req.write;
  wire [3:0] ad = bus_req.addr;
  wire [7:0] wd = bus_req.wdata;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
    hit = (a == want);
  endfunction

  wire [3:0] wave_mode = {timer_control_second[tcr_pkg::BIT_WAVE_HI:tcr_pkg::BIT_WAVE_LO],
                          timer_control_first[1:0]};
  wire [2:0] clock_source_select = timer_control_second[2:0];
  wire capture_noise_filter_enable = timer_control_second[tcr_pkg::BIT_NOISE_FILTER];
  wire capture_edge_select = timer_control_second[tcr_pkg::BIT_EDGE_SELECT];

  // capture as top cuts off the pin
  wire capture_is_top = wave_mode inside {tcr_pkg::WGM_PFC_CAPTOP, tcr_pkg::WGM_PC_CAPTOP,
                                          tcr_pkg::WGM_CTC_CAPTOP, tcr_pkg::WGM_FAST_CAPTOP}; // R6

  // -----------------------------------------------------------------
  // pin synchronisers, three stages; second and third must agree
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cap_sync <= 3'h7;
      ext_sync <= 3'h0;
    end else begin
      cap_sync <= {cap_sync[1:0], capture_input_pin};
      // pin is read whatever its direction, so software can drive it
      ext_sync <= {ext_sync[1:0], external_count_pin}; // R10
    end
  end

  wire cap_stable = (cap_sync[2] == cap_sync[1]);
  wire cap_level  = cap_stable ? cap_sync[2] : cap_prev;
  wire ext_stable = (ext_sync[2] == ext_sync[1]);
  wire ext_level  = ext_stable ? ext_sync[2] : ext_prev;

  tcr_filter u_filter (
    .clock     (clock),
    .nrst      (nrst),
    .enable    (capture_noise_filter_enable),
    .sample_in (cap_level),
    .filtered  (cap_filtered)
  );

  // -----------------------------------------------------------------
  // capture source and edge detect
  // -----------------------------------------------------------------
  // unfiltered path bypasses the filter flop, so the filter adds exactly four cycles
  wire cap_pin  = capture_noise_filter_enable ? cap_filtered : cap_level; // R2
  wire cap_src  = comparator_capture_select ? comparator_out : cap_pin; // R15
  wire cap_rise = cap_src & ~cmp_prev;
  wire cap_fall = ~cap_src & cmp_prev;
  wire cap_edge = capture_edge_select ? cap_rise : cap_fall; // R3
  wire cap_event = cap_edge && !capture_is_top; // R6

  // -----------------------------------------------------------------
  // clock select and prescaler
  // -----------------------------------------------------------------
  wire ext_rise = ext_level & ~ext_prev;
  wire ext_fall = ~ext_level & ext_prev;
  logic tick;
  always_comb begin
    unique case (clock_source_select)
      tcr_pkg::CS_STOP:     tick = 1'b0; // R8
      tcr_pkg::CS_DIRECT:   tick = 1'b1;
      tcr_pkg::CS_DIV8:     tick = (prescale[2:0] == tcr_pkg::TAP_DIV8[2:0]);
      tcr_pkg::CS_DIV64:    tick = (prescale[5:0] == tcr_pkg::TAP_DIV64[5:0]);
      tcr_pkg::CS_DIV256:   tick = (prescale[7:0] == tcr_pkg::TAP_DIV256[7:0]);
      tcr_pkg::CS_DIV1024:  tick = (prescale == tcr_pkg::TAP_DIV1024);
      tcr_pkg::CS_EXT_FALL: tick = ext_fall; // R9
      tcr_pkg::CS_EXT_RISE: tick = ext_rise; // R9
    endcase
  end

  // -----------------------------------------------------------------
  // 16-bit access through the shared high-byte latch
  // -----------------------------------------------------------------
  // low write commits latch plus data; counter or capture low read loads latch with its high byte
  wire wr_cnt_lo = wr && hit(ad, tcr_pkg::ADDR_COUNTER_LO);
  wire wr_cmp_a  = wr && hit(ad, tcr_pkg::ADDR_COMPARE_A_LO);
  wire wr_cmp_b  = wr && hit(ad, tcr_pkg::ADDR_COMPARE_B_LO);
  wire wr_cap_lo = wr && hit(ad, tcr_pkg::ADDR_CAPTURE_LO);
  wire wr_hi     = wr && ad[0] && (ad >= tcr_pkg::ADDR_COUNTER_HI) &&
                   (ad <= tcr_pkg::ADDR_CAPTURE_HI);
  wire rd_cnt_lo = bus_req.read && hit(ad, tcr_pkg::ADDR_COUNTER_LO);
  wire rd_cap_lo = bus_req.read && hit(ad, tcr_pkg::ADDR_CAPTURE_LO);
  wire [15:0] wide_wd = {high_latch, wd};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      high_latch <= tcr_pkg::RESET_BYTE;
    end else if (wr_hi) begin
      high_latch <= wd; // R23
    end else if (rd_cnt_lo) begin
      high_latch <= counter_value[15:8]; // R11
    end else if (rd_cap_lo) begin
      high_latch <= capture_value[15:8]; // R16
    end
  end

  // -----------------------------------------------------------------
  // counter, prescaler, compare blocking
  // -----------------------------------------------------------------
  wire next_overflow = tick && (counter_value == tcr_pkg::COUNT_MAX);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      counter_value <= tcr_pkg::RESET_WORD;
      prescale      <= 10'h000;
      write_block   <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      if (wr_cnt_lo) begin
        counter_value <= wide_wd; // R11
        write_block   <= 1'b1;
      end else if (tick) begin
        counter_value <= counter_value + 16'h0001;
        write_block   <= 1'b0; // R12
      end
    end
  end

  // -----------------------------------------------------------------
  // compare match, evaluated on each timer tick
  // -----------------------------------------------------------------
  wire eq_a = (counter_value == compare_value_a); // R13
  wire eq_b = (counter_value == compare_value_b); // R13
  wire hit_a = tick && eq_a && !write_block && !wr_cnt_lo; // R12 R21
  wire hit_b = tick && eq_b && !write_block && !wr_cnt_lo; // R12 R21

  // -----------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      timer_control_first  <= tcr_pkg::RESET_BYTE;
      timer_control_second <= tcr_pkg::RESET_BYTE;
      timer_irq_mask       <= tcr_pkg::RESET_BYTE;
      compare_value_a      <= tcr_pkg::RESET_WORD;
      compare_value_b      <= tcr_pkg::RESET_WORD;
    end else begin
      if (wr && hit(ad, tcr_pkg::ADDR_CONTROL_FIRST))
        timer_control_first <= wd;
      // reserved bit kept at zero; software should write it as zero
      if (wr && hit(ad, tcr_pkg::ADDR_CONTROL_SECOND))
        timer_control_second <= wd & ~(8'h01 << tcr_pkg::BIT_RESERVED); // R7
      if (wr && hit(ad, tcr_pkg::ADDR_IRQ_MASK))
        timer_irq_mask <= wd; // R17 R18 R19 R20
      if (wr_cmp_a)
        compare_value_a <= wide_wd; // R14
      if (wr_cmp_b)
        compare_value_b <= wide_wd; // R14
    end
  end

  // -----------------------------------------------------------------
  // capture register
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      capture_value <= tcr_pkg::RESET_WORD;
      cap_prev      <= 1'b1;
      ext_prev      <= 1'b0;
      cmp_prev      <= 1'b1;
    end else begin
      if (ext_stable)
        ext_prev <= ext_sync[2];
      if (cap_stable)
        cap_prev <= cap_sync[2];
      cmp_prev <= cap_src;
      if (cap_event)
        capture_value <= counter_value; // R4
      else if (wr_cap_lo)
        capture_value <= wide_wd; // R15
    end
  end

  // -----------------------------------------------------------------
  // flags: hardware set wins over vector ack and write-one clear
  // -----------------------------------------------------------------
  wire wr_flags = wr && hit(ad, tcr_pkg::ADDR_IRQ_FLAGS);
  wire [7:0] clr_write = wr_flags ? (wd & tcr_pkg::FLAG_MASK) : 8'h00;
  wire [7:0] clr_ack = {vector_ack.overflow, vector_ack.compare_a, vector_ack.compare_b,
                        1'b0, vector_ack.capture, 3'h0};
  wire cap_top_reach = capture_is_top && tick && (counter_value == capture_value);
  wire [7:0] set_bits = {next_overflow, hit_a, hit_b, 1'b0,
                         cap_event || cap_top_reach, 3'h0}; // R4 R21
  wire [7:0] next_flags = (timer_irq_flags & ~(clr_write | clr_ack)) | set_bits; // R22

  always_ff @(posedge clock) begin
    if (!nrst) begin
      timer_irq_flags <= tcr_pkg::RESET_BYTE;
      match_a         <= 1'b0;
      match_b         <= 1'b0;
    end else begin
      timer_irq_flags <= next_flags;
      match_a         <= hit_a; // R13
      match_b         <= hit_b;
    end
  end

  // -----------------------------------------------------------------
  // interrupt requests
  // -----------------------------------------------------------------
  wire [7:0] pend = next_flags & timer_irq_mask & {8{global_irq_enable}};
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_request <= '0;
    end else begin
      irq_request.overflow  <= pend[tcr_pkg::BIT_OVERFLOW]; // R17
      irq_request.compare_a <= pend[tcr_pkg::BIT_COMPARE_A]; // R18
      irq_request.compare_b <= pend[tcr_pkg::BIT_COMPARE_B]; // R19
      irq_request.capture   <= pend[tcr_pkg::BIT_CAPTURE]; // R5 R20
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    unique case (ad)
      tcr_pkg::ADDR_CONTROL_FIRST:  next_rdata = timer_control_first;
      tcr_pkg::ADDR_CONTROL_SECOND: next_rdata = timer_control_second;
      tcr_pkg::ADDR_COUNTER_LO:     next_rdata = counter_value[7:0];
      tcr_pkg::ADDR_COMPARE_A_LO:   next_rdata = compare_value_a[7:0];
      tcr_pkg::ADDR_COMPARE_A_HI:   next_rdata = compare_value_a[15:8];
      tcr_pkg::ADDR_COMPARE_B_LO:   next_rdata = compare_value_b[7:0];
      tcr_pkg::ADDR_COMPARE_B_HI:   next_rdata = compare_value_b[15:8];
      tcr_pkg::ADDR_CAPTURE_LO:     next_rdata = capture_value[7:0];
      tcr_pkg::ADDR_COUNTER_HI,
      tcr_pkg::ADDR_CAPTURE_HI:     next_rdata = high_latch; // R11 R16
      tcr_pkg::ADDR_IRQ_MASK:       next_rdata = timer_irq_mask;
      tcr_pkg::ADDR_IRQ_FLAGS:      next_rdata = timer_irq_flags;
      default:                      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst)
      rdata <= 8'h00;
    else if (bus_req.read)
      rdata <= next_rdata;
  end

endmodule

// ===== dv/tcr_core_model.sv
// Purpose: processor core model driving the timer register bus
// Assumes: one-cycle strobes, read data valid the cycle after a read
// Notes:   16-bit writes and counter/capture reads pass through the shared high-byte latch
`timescale 1ns/100ps
module tcr_core_model (
  input  wire logic             clock,
  output tcr_pkg::tcr_bus_req_t bus_req,
  input  wire logic [7:0]       rdata
);
  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  initial bus_req = '0;

  // reserved control bit always goes out as zero
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == tcr_pkg::ADDR_CONTROL_SECOND) v[tcr_pkg::BIT_RESERVED] = 1'b0;
    @(posedge clock) bus_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
    @(posedge clock) bus_req <= '0;
  endtask

  // data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock) bus_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock) bus_req <= '0;
    @(posedge clock) d = rdata;
  endtask

  // high byte first on writes, low byte first on reads
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(a + 4'h1, d[15:8]);
    wr(a, d[7:0]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 4'h1, d[15:8]);
  endtask
endmodule

// ===== dv/tcr_timer_checker.sv
// Purpose: port-level assertions for the 16-bit timer
// Assumes: single clock, synchronous active-low reset
// Notes:   mask shadowed from bus writes
`timescale 1ns/100ps
module tcr_timer_checker (
  input wire logic                  clock,
  input wire logic                  nrst,
  input wire tcr_pkg::tcr_bus_req_t bus_req,
  input wire logic [7:0]            rdata,
  input wire logic                  global_irq_enable,
  input wire tcr_pkg::tcr_irq_t     vector_ack,
  input wire tcr_pkg::tcr_irq_t     irq_request,
  input wire logic                  match_a,
  input wire logic                  match_b
);
  // ------------------------------------------------------------------
  // helper and properties
  // ------------------------------------------------------------------
  logic [7:0] mask_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // shadow of the mask; requests may lag a mask change by one cycle
  always_ff @(posedge clock) begin
    if (!nrst) mask_q <= 8'h00;
    else if (bus_req.write && bus_req.addr == tcr_pkg::ADDR_IRQ_MASK) mask_q <= bus_req.wdata;
  end

  rdata_hold_a: assert property (
    !$past(bus_req.read) |-> $stable(rdata)) else $error("read data moved");
  unmapped_zero_a: assert property (
    bus_req.read && bus_req.addr > tcr_pkg::ADDR_IRQ_FLAGS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (
    bus_req.read && bus_req.addr == tcr_pkg::ADDR_CONTROL_SECOND |=> !rdata[5])
    else $error("reserved bit reads one");
  global_gate_a: assert property (
    !global_irq_enable && !$past(global_irq_enable) |-> irq_request == '0)
    else $error("request while globally disabled");
  ovf_mask_a: assert property (
    irq_request.overflow |-> mask_q[7] || $past(mask_q[7])) else $error("overflow unmasked");
  cmpa_mask_a: assert property (
    irq_request.compare_a |-> mask_q[6] || $past(mask_q[6])) else $error("compare a unmasked");
  cmpb_mask_a: assert property (
    irq_request.compare_b |-> mask_q[5] || $past(mask_q[5])) else $error("compare b unmasked");
  cap_mask_a: assert property (
    irq_request.capture |-> mask_q[3] || $past(mask_q[3])) else $error("capture unmasked");
  match_pulse_a: assert property (
    match_a |=> !match_a) else $error("match a longer than one cycle");
  matchb_pulse_a: assert property (
    $rose(match_b) |=> $fell(match_b)) else $error("match b longer than one cycle");
  cmpa_request_a: assert property (
    match_a && mask_q[6] && global_irq_enable && $past(global_irq_enable)
    && vector_ack == '0 |-> ##[0:1] irq_request.compare_a) else $error("compare a request lost");
endmodule

bind tcr_timer tcr_timer_checker chk (.*);

// ===== dv/tcr_timer_tb.sv
// Purpose: self-checking bench for the 16-bit timer block
// Assumes: core model drives the register bus, bench drives the pins
// Notes:   the slowest prescaler tap sets the run length
`timescale 1ns/100ps
module tcr_timer_tb;
  // ------------------------------------------------------------------
  // harness
  // ------------------------------------------------------------------
  logic                  clock = 1'b0;
  logic                  nrst = 1'b0;
  tcr_pkg::tcr_bus_req_t bus_req;
  logic [7:0]            rdata, b;
  logic                  global_irq_enable = 1'b0;
  tcr_pkg::tcr_irq_t     vector_ack = '0;
  tcr_pkg::tcr_irq_t     irq_request;
  logic                  capture_input_pin = 1'b1;
  logic                  comparator_out = 1'b0;
  logic                  comparator_capture_select = 1'b0;
  logic                  external_count_pin = 1'b0;
  logic                  match_a, match_b;
  int                    num_errors = 0;
  int                    checked = 0;
  logic [15:0]           w;
  int                    n0, n1;
  wire [3:0]             watch = {irq_request.overflow, match_b, match_a, irq_request.capture};

  always #5 clock = ~clock;
  tcr_core_model core (.*);
  tcr_timer uut (.*);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait, n counts edges
  task automatic wait_bit(input int k, output int n);
    n = 0;
    while (watch[k] !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n == 100) begin
      num_errors++;
      give_verdict();
    end
  endtask

  // clear flag after mode change
  task automatic cap_event(input logic [7:0] ctrl, input logic hit, output int n);
    @(posedge clock) capture_input_pin <= ~ctrl[6];
    repeat (12) @(posedge clock);
    core.wr(tcr_pkg::ADDR_CONTROL_SECOND, ctrl);
    core.wr(tcr_pkg::ADDR_IRQ_FLAGS, 8'h08);
    @(posedge clock) capture_input_pin <= ctrl[6];
    n = 0;
    if (hit) wait_bit(0, n);
    else repeat (20) @(posedge clock);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic run_regs();
    core.rd16(tcr_pkg::ADDR_COMPARE_A_LO, w);
    check(w, 16'h0000);
    core.rd(tcr_pkg::ADDR_IRQ_MASK, b);
    check(b, 8'h00);
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h1234);
    core.rd16(tcr_pkg::ADDR_COUNTER_LO, w);
    check(w, 16'h1234);
    core.wr16(tcr_pkg::ADDR_COMPARE_B_LO, 16'habcd);
    core.rd16(tcr_pkg::ADDR_COMPARE_B_LO, w);
    check(w, 16'habcd);
    // a lone high byte only loads the latch
    core.wr(tcr_pkg::ADDR_COUNTER_HI, 8'h77);
    core.rd16(tcr_pkg::ADDR_COUNTER_LO, w);
    check(w, 16'h1234);
    core.rd(4'hc, b);
    check(b, 8'h00);
  endtask

  task automatic run_compare();
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h0010);
    core.wr16(tcr_pkg::ADDR_COMPARE_A_LO, 16'h0014);
    core.wr16(tcr_pkg::ADDR_COMPARE_B_LO, 16'h0016);
    core.wr(tcr_pkg::ADDR_IRQ_MASK, 8'he8);
    global_irq_enable <= 1'b1;
    core.wr(tcr_pkg::ADDR_CONTROL_SECOND, {5'h00, tcr_pkg::CS_DIRECT});
    wait_bit(1, n0);
    wait_bit(2, n1);
    check(16'(n1), 16'h0002);
    repeat (2) @(posedge clock);
    check({irq_request.compare_a, irq_request.compare_b}, 2'b11);
    vector_ack <= 4'b0100;
    @(posedge clock) vector_ack <= '0;
    repeat (2) @(posedge clock);
    check({irq_request.compare_a, irq_request.compare_b}, 2'b01);
    core.wr(tcr_pkg::ADDR_IRQ_FLAGS, 8'h20);
    @(posedge clock);
    check(irq_request.compare_b, 1'b0);
    // counter written onto compare value: no match
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h0014);
    repeat (4) @(posedge clock);
    core.rd(tcr_pkg::ADDR_IRQ_FLAGS, b);
    check(b & 8'h40, 8'h00);
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'hfff0);
    wait_bit(3, n0);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clock);
    check(irq_request.overflow, 1'b0);
    global_irq_enable <= 1'b1;
    core.wr(tcr_pkg::ADDR_CONTROL_SECOND, 8'h00);
    core.wr(tcr_pkg::ADDR_IRQ_FLAGS, 8'he8);
  endtask

  task automatic run_capture();
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h0055);
    core.wr(tcr_pkg::ADDR_IRQ_MASK, 8'h08);
    cap_event(8'h40, 1'b1, n0);
    core.rd16(tcr_pkg::ADDR_CAPTURE_LO, w);
    check(w, 16'h0055);
    cap_event(8'h00, 1'b1, n1);
    cap_event(8'hc0, 1'b1, n1);
    check(16'(n1 - n0), 16'h0004);
    // three low samples: too few for the filter
    core.wr(tcr_pkg::ADDR_IRQ_FLAGS, 8'h08);
    @(posedge clock) capture_input_pin <= 1'b0;
    repeat (3) @(posedge clock);
    capture_input_pin <= 1'b1;
    repeat (20) @(posedge clock);
    check(irq_request.capture, 1'b0);
    core.wr(tcr_pkg::ADDR_IRQ_MASK, 8'h00);
    cap_event(8'h40, 1'b0, n0);
    check(irq_request.capture, 1'b0);
    core.rd(tcr_pkg::ADDR_IRQ_FLAGS, b);
    check(b & 8'h08, 8'h08);
    core.wr(tcr_pkg::ADDR_IRQ_MASK, 8'h08);
    comparator_capture_select <= 1'b1;
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h0066);
    core.wr(tcr_pkg::ADDR_IRQ_FLAGS, 8'h08);
    @(posedge clock) comparator_out <= 1'b1;
    wait_bit(0, n0);
    core.rd16(tcr_pkg::ADDR_CAPTURE_LO, w);
    check(w, 16'h0066);
    comparator_capture_select <= 1'b0;
    // capture register as top: the pin is cut off
    core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h0001);
    cap_event(8'h58, 1'b0, n0);
    check(irq_request.capture, 1'b0);
    core.rd16(tcr_pkg::ADDR_CAPTURE_LO, w);
    check(w, 16'h0066);
  endtask

  task automatic run_clocks();
    int div [6] = '{0, 1, 8, 64, 256, 1024};
    for (int c = 0; c < 8; c++) begin
      core.wr16(tcr_pkg::ADDR_COUNTER_LO, 16'h0000);
      core.wr(tcr_pkg::ADDR_CONTROL_SECOND, 8'(c));
      if (c > 5) begin
        repeat (3) begin
          @(posedge clock) external_count_pin <= 1'b1;
          repeat (8) @(posedge clock);
          external_count_pin <= 1'b0;
          repeat (8) @(posedge clock);
        end
      end
      else repeat (c == 0 ? 64 : 8 * div[c]) @(posedge clock);
      core.wr(tcr_pkg::ADDR_CONTROL_SECOND, 8'h00);
      core.rd16(tcr_pkg::ADDR_COUNTER_LO, w);
      if (c > 5) check(w, 16'h0003);
      else if (c == 0) check(w, 16'h0000);
      else check(16'(w >= 16'h0007 && w <= 16'h000a), 16'h0001);
    end
  endtask

  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    run_regs();
    run_compare();
    run_capture();
    run_clocks();
    give_verdict();
  end
endmodule
